// ===== irq_src_defs.svh
// Offsets, field layouts, reset values and bus codes of the interrupt source block.
// Assumes a byte-addressed AXI4-Lite register window of 32 bytes.
`ifndef IRQ_SRC_DEFS_SVH
`define IRQ_SRC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define DELAY_REQUEST_OFS      8'h00
`define DETECT_SELECT_OFS      8'h04
`define EXT_IRQ_ENABLE_OFS     8'h08
`define EXT_IRQ_CAUSE_OFS      8'h0c
`define IRQ_LEVEL_CONTROL_OFS  8'h10
`define TRANSFER_COUNT_OFS     8'h14
`define EVENT_STATUS_OFS       8'h18
`define EVENT_MASK_OFS         8'h1c

// ----------------------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------------------
`define DELAY_REQUEST_BIT      0
`define DETECT_FIELD_W         2
`define EXT_INPUTS             5
`define EXT_VECTORS            3
`define XFER_COUNT_W           8
`define EVENT_W                6
`define EVENT_DELAY_BIT        0
`define EVENT_CAUSE_LSB        1
// Inputs 0,1 -> vector 15; inputs 2,3 -> vector 24; input 4 (bus receive) -> vector 27
`define VEC0_PINS              5'h03
`define VEC1_PINS              5'h0c
`define VEC2_PINS              5'h10
`define DELAY_IRQ_NUMBER       8'h2a
`define VEC0_IRQ_NUMBER        8'h0f
`define VEC1_IRQ_NUMBER        8'h18
`define VEC2_IRQ_NUMBER        8'h1b

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DELAY_REQUEST_RST      1'h0
`define DETECT_SELECT_RST      10'h000
`define EXT_IRQ_ENABLE_RST     5'h00
`define EXT_IRQ_CAUSE_RST      5'h00
`define IRQ_LEVEL_CONTROL_RST  3'h0
`define TRANSFER_COUNT_RST     8'h01
`define EVENT_STATUS_RST       6'h00
`define EVENT_MASK_RST         6'h00

// ----------------------------------------------------------------------------
// Bus answer codes
// ----------------------------------------------------------------------------
`define AXI_RESP_OKAY          2'h0
`define AXI_RESP_SLVERR        2'h2

`endif

// ===== irq_src_pkg.sv
// Types shared by the interrupt source block.
// Assumes nothing of its surroundings.
package irq_src_pkg;

    // ------------------------------------------------------------------------
    // Detection modes of one external input, in field order
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        DET_LOW_LEVEL,
        DET_HIGH_LEVEL,
        DET_RISING_EDGE,
        DET_FALLING_EDGE
    } detect_mode_e;

    // ------------------------------------------------------------------------
    // Register decode result
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        REG_DELAY,
        REG_DETECT,
        REG_ENABLE,
        REG_CAUSE,
        REG_LEVEL_CTRL,
        REG_XFER_COUNT,
        REG_STATUS,
        REG_MASK,
        REG_NONE
    } reg_sel_e;

endpackage

// ===== pin_detect.sv
// One external request input: two-stage synchroniser and level/edge detector.
// Assumes the pin is asynchronous to clk_i and rst_n_i is already synchronised.
`timescale 1ns/1ps
`default_nettype none

module pin_detect (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      pin_i,
    input  wire irq_src_pkg::detect_mode_e mode_i,
    output logic                           hit_o
);

    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    logic [2:0] warm_ff, nxt_warm;
    logic nxt_meta;
    logic nxt_sync;
    logic nxt_prev;

    // ------------------------------------------------------------------------
    // Synchroniser and history
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_meta = pin_i;
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
        nxt_warm = {warm_ff[1:0], 1'h1};  // No hit until sync and history hold real pin samples
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= 1'h0;
            sync_ff <= 1'h0;
            prev_ff <= 1'h0;
            warm_ff <= 3'h0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
            warm_ff <= nxt_warm;
        end
    end

    // ------------------------------------------------------------------------
    // Detection: levels hold while true, edges last one cycle
    // ------------------------------------------------------------------------
    always_comb begin
        case (mode_i)
            irq_src_pkg::DET_LOW_LEVEL:    hit_o = !sync_ff && warm_ff[2];
            irq_src_pkg::DET_HIGH_LEVEL:   hit_o = sync_ff && warm_ff[2];
            irq_src_pkg::DET_RISING_EDGE:  hit_o = sync_ff && !prev_ff && warm_ff[2];
            irq_src_pkg::DET_FALLING_EDGE: hit_o = !sync_ff && prev_ff && warm_ff[2];
            default:                       hit_o = 1'h0;
        endcase
    end

endmodule
`default_nettype wire

// ===== irq_sources.sv
// Software delay interrupt and five-input external interrupt unit with AXI4-Lite registers.
// Assumes one 25 MHz clock, an asynchronous active-low reset and a transfer service on the same clock.
//
// Notes on behaviour
// - Writing one raises delay request, held.
// - Writing zero withdraws delay request.
// - Delay request goes out as vector 42.
// - Delay request has no enable gate.
// - Delay request bit reads back as flag.
// - Delay request never starts transfer service.
// - Delay setting latched until next write.
// - Five inputs: four pins plus bus receive.
// - Bus receive line raises wakeup interrupt.
// - Per-input high, low, rising, falling detection.
// - Per-input enable gates forwarding to CPU.
// - Per-input cause flag records detected request.
// - Select zero: request branches to handler directly.
// - Select one: transfers first, then handler.
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "irq_src_defs.svh"

module irq_sources #(
    parameter int ADDR_W = 8
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic [ADDR_W-1:0]        s_axi_awaddr_i,
    input  wire logic                     s_axi_awvalid_i,
    output logic                          s_axi_awready_o,
    input  wire logic [31:0]              s_axi_wdata_i,
    input  wire logic [3:0]               s_axi_wstrb_i,
    input  wire logic                     s_axi_wvalid_i,
    output logic                          s_axi_wready_o,
    output logic [1:0]                    s_axi_bresp_o,
    output logic                          s_axi_bvalid_o,
    input  wire logic                     s_axi_bready_i,
    input  wire logic [ADDR_W-1:0]        s_axi_araddr_i,
    input  wire logic                     s_axi_arvalid_i,
    output logic                          s_axi_arready_o,
    output logic [31:0]                   s_axi_rdata_o,
    output logic [1:0]                    s_axi_rresp_o,
    output logic                          s_axi_rvalid_o,
    input  wire logic                     s_axi_rready_i,
    input  wire logic [3:0]               ext_irq_pin_i,
    input  wire logic                     can_rx_i,
    input  wire logic [`EXT_VECTORS-1:0]  xfer_ack_i,
    output logic                          delay_irq_o,
    output logic [`EXT_VECTORS-1:0]       ext_branch_irq_o,
    output logic [`EXT_VECTORS-1:0]       ext_xfer_req_o,
    output logic                          irq_o
);

    localparam int NIN  = `EXT_INPUTS;
    localparam int NVEC = `EXT_VECTORS;
    localparam logic [NIN-1:0] VEC_PINS [NVEC] = '{`VEC0_PINS, `VEC1_PINS, `VEC2_PINS};
    if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
        $error("ADDR_W must lie between 5 and 8");
    end

    // ------------------------------------------------------------------------
    // Decode and byte-lane helpers
    // ------------------------------------------------------------------------
    function automatic irq_src_pkg::reg_sel_e reg_decode(input logic [ADDR_W-1:0] addr);
        logic [7:0] a;
        a = 8'(addr);
        case (a)
            `DELAY_REQUEST_OFS:     reg_decode = irq_src_pkg::REG_DELAY;
            `DETECT_SELECT_OFS:     reg_decode = irq_src_pkg::REG_DETECT;
            `EXT_IRQ_ENABLE_OFS:    reg_decode = irq_src_pkg::REG_ENABLE;
            `EXT_IRQ_CAUSE_OFS:     reg_decode = irq_src_pkg::REG_CAUSE;
            `IRQ_LEVEL_CONTROL_OFS: reg_decode = irq_src_pkg::REG_LEVEL_CTRL;
            `TRANSFER_COUNT_OFS:    reg_decode = irq_src_pkg::REG_XFER_COUNT;
            `EVENT_STATUS_OFS:      reg_decode = irq_src_pkg::REG_STATUS;
            `EVENT_MASK_OFS:        reg_decode = irq_src_pkg::REG_MASK;
            default:                reg_decode = irq_src_pkg::REG_NONE;
        endcase
    endfunction
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    logic rst_meta_ff, rst_sync_ff;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_ff <= 1'h0;
            rst_sync_ff <= 1'h0;
        end else begin
            rst_meta_ff <= 1'h1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------------
    // Input detection
    // ------------------------------------------------------------------------
    logic [NIN-1:0]       pins, hit;
    logic [2*NIN-1:0]     detect_sel_ff, nxt_detect_sel;
    assign pins = {can_rx_i, ext_irq_pin_i};
    for (genvar i = 0; i < NIN; i++) begin : g_pin
        pin_detect u_det (
            .clk_i   (ref_clk_i),
            .rst_n_i (rst_sync_ff),
            .pin_i   (pins[i]),
            .mode_i  (irq_src_pkg::detect_mode_e'(detect_sel_ff[2*i +: 2])),
            .hit_o   (hit[i])
        );
    end

    // ------------------------------------------------------------------------
    // Bus and register state
    // ------------------------------------------------------------------------
    logic                     aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held, wr_fire;
    logic [ADDR_W-1:0]        aw_addr_ff, nxt_aw_addr;
    logic [31:0]              w_data_ff, nxt_w_data, rdata_ff, nxt_rdata, wr_mask;
    logic [3:0]               w_strb_ff, nxt_w_strb;
    logic                     awready_ff, nxt_awready, wready_ff, nxt_wready, arready_ff, nxt_arready;
    logic                     bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0]               bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    irq_src_pkg::reg_sel_e    wr_sel;
    logic                     delay_req_ff, nxt_delay_req, delay_irq_ff, nxt_delay_irq, irq_ff, nxt_irq;
    logic [NIN-1:0]           enable_ff, nxt_enable, cause_ff, nxt_cause, cause_clr;
    logic [NVEC-1:0]          xfer_sel_ff, nxt_xfer_sel, branch_ff, nxt_branch, xreq_ff, nxt_xreq;
    logic [`XFER_COUNT_W-1:0] xfer_count_ff, nxt_xfer_count, remain_ff [NVEC], nxt_remain [NVEC];
    logic [`EVENT_W-1:0]      status_ff, nxt_status, mask_ff, nxt_mask, events;

    // ------------------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------------------
    always_comb begin
        wr_fire     = aw_held_ff && w_held_ff && !bvalid_ff;
        wr_sel      = reg_decode(aw_addr_ff);
        wr_mask     = lane_mask(w_strb_ff);
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held  = w_held_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_strb  = w_strb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        if (s_axi_awvalid_i && awready_ff) begin
            nxt_aw_held = 1'h1;
            nxt_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && wready_ff) begin
            nxt_w_held = 1'h1;
            nxt_w_data = s_axi_wdata_i;
            nxt_w_strb = s_axi_wstrb_i;
        end
        if (bvalid_ff && s_axi_bready_i) begin
            nxt_bvalid = 1'h0;
        end
        if (wr_fire) begin
            nxt_aw_held = 1'h0;
            nxt_w_held  = 1'h0;
            nxt_bvalid  = 1'h1;
            nxt_bresp   = (wr_sel == irq_src_pkg::REG_NONE) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
        end
        // One write in flight: no new address or data until the answer is taken
        nxt_awready = !nxt_aw_held && !nxt_bvalid;
        nxt_wready  = !nxt_w_held && !nxt_bvalid;
        nxt_arready = arready_ff || !rvalid_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        if (rvalid_ff && s_axi_rready_i) begin
            nxt_rvalid  = 1'h0;
            nxt_arready = 1'h1;
        end
        if (s_axi_arvalid_i && arready_ff) begin
            nxt_arready = 1'h0;
            nxt_rvalid  = 1'h1;
            nxt_rresp   = `AXI_RESP_OKAY;
            nxt_rdata   = 32'h0;
            case (reg_decode(s_axi_araddr_i))
                irq_src_pkg::REG_DELAY:      nxt_rdata[`DELAY_REQUEST_BIT] = delay_req_ff;
                irq_src_pkg::REG_DETECT:     nxt_rdata[2*NIN-1:0] = detect_sel_ff;
                irq_src_pkg::REG_ENABLE:     nxt_rdata[NIN-1:0] = enable_ff;
                irq_src_pkg::REG_CAUSE:      nxt_rdata[NIN-1:0] = cause_ff;
                irq_src_pkg::REG_LEVEL_CTRL: nxt_rdata[NVEC-1:0] = xfer_sel_ff;
                irq_src_pkg::REG_XFER_COUNT: nxt_rdata[`XFER_COUNT_W-1:0] = xfer_count_ff;
                irq_src_pkg::REG_STATUS:     nxt_rdata[`EVENT_W-1:0] = status_ff;
                irq_src_pkg::REG_MASK:       nxt_rdata[`EVENT_W-1:0] = mask_ff;
                default:                     nxt_rresp = `AXI_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            aw_held_ff <= 1'h0;
            aw_addr_ff <= '0;
            w_held_ff  <= 1'h0;
            w_data_ff  <= 32'h0;
            w_strb_ff  <= 4'h0;
            awready_ff <= 1'h0;
            wready_ff  <= 1'h0;
            bvalid_ff  <= 1'h0;
            bresp_ff   <= `AXI_RESP_OKAY;
            arready_ff <= 1'h0;
            rvalid_ff  <= 1'h0;
            rdata_ff   <= 32'h0;
            rresp_ff   <= `AXI_RESP_OKAY;
        end else begin
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
            w_held_ff  <= nxt_w_held;
            w_data_ff  <= nxt_w_data;
            w_strb_ff  <= nxt_w_strb;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    // ------------------------------------------------------------------------
    // Registers, cause flags and request routing
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_delay_req  = delay_req_ff;
        nxt_detect_sel = detect_sel_ff;
        nxt_enable     = enable_ff;
        nxt_xfer_sel   = xfer_sel_ff;
        nxt_xfer_count = xfer_count_ff;
        nxt_mask       = mask_ff;
        cause_clr      = '0;
        events         = '0;
        nxt_remain     = remain_ff;
        if (wr_fire) begin
            case (wr_sel)
                irq_src_pkg::REG_DELAY: begin
                    if (wr_mask[`DELAY_REQUEST_BIT]) begin
                        nxt_delay_req = w_data_ff[`DELAY_REQUEST_BIT];
                    end
                end
                irq_src_pkg::REG_DETECT: begin
                    nxt_detect_sel = (detect_sel_ff & ~wr_mask[2*NIN-1:0]) |
                                     (w_data_ff[2*NIN-1:0] & wr_mask[2*NIN-1:0]);
                end
                irq_src_pkg::REG_ENABLE: begin
                    nxt_enable = (enable_ff & ~wr_mask[NIN-1:0]) | (w_data_ff[NIN-1:0] & wr_mask[NIN-1:0]);
                end
                irq_src_pkg::REG_CAUSE:      cause_clr = w_data_ff[NIN-1:0] & wr_mask[NIN-1:0];
                irq_src_pkg::REG_LEVEL_CTRL: begin
                    nxt_xfer_sel = (xfer_sel_ff & ~wr_mask[NVEC-1:0]) | (w_data_ff[NVEC-1:0] & wr_mask[NVEC-1:0]);
                end
                irq_src_pkg::REG_XFER_COUNT: begin
                    if (wr_mask[0]) begin
                        nxt_xfer_count = w_data_ff[`XFER_COUNT_W-1:0];
                        nxt_remain     = '{default: w_data_ff[`XFER_COUNT_W-1:0]};
                    end
                end
                irq_src_pkg::REG_MASK: begin
                    nxt_mask = (mask_ff & ~wr_mask[`EVENT_W-1:0]) | (w_data_ff[`EVENT_W-1:0] & wr_mask[`EVENT_W-1:0]);
                end
                default: ;
            endcase
        end
        // A detection in the clearing cycle keeps the flag set
        nxt_cause = (cause_ff & ~cause_clr) | hit;
        events[`EVENT_DELAY_BIT] = nxt_delay_req && !delay_req_ff;
        events[`EVENT_CAUSE_LSB +: NIN] = hit & ~cause_ff;
        nxt_status = status_ff;
        if (wr_fire && wr_sel == irq_src_pkg::REG_STATUS) begin
            nxt_status = status_ff & ~(w_data_ff[`EVENT_W-1:0] & wr_mask[`EVENT_W-1:0]);
        end
        nxt_status = nxt_status | events;
        nxt_irq    = |(nxt_status & nxt_mask);
        // Delay request goes straight out, never through the transfer path
        nxt_delay_irq = nxt_delay_req;
        for (int v = 0; v < NVEC; v++) begin
            logic pend;
            pend = |(cause_ff & enable_ff & VEC_PINS[v]);
            if (xreq_ff[v] && xfer_ack_i[v] && remain_ff[v] != '0) begin
                nxt_remain[v] = remain_ff[v] - `XFER_COUNT_W'(1);
            end
            // Limitation: under transfer the cause stays set, so one edge keeps requesting until the count runs out or the cause is cleared
            nxt_xreq[v]   = xfer_sel_ff[v] && pend && nxt_remain[v] != '0 && !(xreq_ff[v] && xfer_ack_i[v]);
            nxt_branch[v] = pend && (!xfer_sel_ff[v] || nxt_remain[v] == '0);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            delay_req_ff  <= `DELAY_REQUEST_RST;
            detect_sel_ff <= `DETECT_SELECT_RST;
            enable_ff     <= `EXT_IRQ_ENABLE_RST;
            cause_ff      <= `EXT_IRQ_CAUSE_RST;
            xfer_sel_ff   <= `IRQ_LEVEL_CONTROL_RST;
            xfer_count_ff <= `TRANSFER_COUNT_RST;
            status_ff     <= `EVENT_STATUS_RST;
            mask_ff       <= `EVENT_MASK_RST;
            branch_ff     <= '0;
            xreq_ff       <= '0;
            delay_irq_ff  <= 1'h0;
            irq_ff        <= 1'h0;
            remain_ff     <= '{default: `TRANSFER_COUNT_RST};
        end else begin
            delay_req_ff  <= nxt_delay_req;
            detect_sel_ff <= nxt_detect_sel;
            enable_ff     <= nxt_enable;
            cause_ff      <= nxt_cause;
            xfer_sel_ff   <= nxt_xfer_sel;
            xfer_count_ff <= nxt_xfer_count;
            status_ff     <= nxt_status;
            mask_ff       <= nxt_mask;
            branch_ff     <= nxt_branch;
            xreq_ff       <= nxt_xreq;
            delay_irq_ff  <= nxt_delay_irq;
            irq_ff        <= nxt_irq;
            remain_ff     <= nxt_remain;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign {s_axi_awready_o, s_axi_wready_o} = {awready_ff, wready_ff};
    assign {s_axi_bvalid_o, s_axi_bresp_o} = {bvalid_ff, bresp_ff};
    assign {s_axi_arready_o, s_axi_rvalid_o, s_axi_rresp_o} = {arready_ff, rvalid_ff, rresp_ff};
    assign s_axi_rdata_o = rdata_ff;
    assign {delay_irq_o, irq_o} = {delay_irq_ff, irq_ff};
    assign {ext_branch_irq_o, ext_xfer_req_o} = {branch_ff, xreq_ff};

endmodule
`default_nettype wire

// ===== irq_sources_asserts.sv
// Port checker for the interrupt source block.
// Assumes a bind into irq_sources, ports matched by name.
`timescale 1ns/1ps
`default_nettype none
module irq_sources_asserts (
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    input wire logic       s_axi_awvalid_i,
    input wire logic       s_axi_awready_o,
    input wire logic       s_axi_bvalid_o,
    input wire logic       s_axi_arvalid_i,
    input wire logic       s_axi_arready_o,
    input wire logic       s_axi_rvalid_o,
    input wire logic [2:0] xfer_ack_i,
    input wire logic       delay_irq_o,
    input wire logic [2:0] ext_branch_irq_o,
    input wire logic [2:0] ext_xfer_req_o
);
    // --------
    // Checks
    // --------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence wr_take; s_axi_awvalid_i && s_axi_awready_o; endsequence
    sequence b_next; !s_axi_bvalid_o ##1 s_axi_bvalid_o; endsequence
    dly_set_a: assert property ($rose(delay_irq_o) |-> s_axi_bvalid_o)
        else $error("delay request rose without a write");
    dly_clr_a: assert property ($fell(delay_irq_o) |-> s_axi_bvalid_o)
        else $error("delay request fell without a write");
    wr_answer_a: assert property (wr_take |=> b_next)
        else $error("write answer timing wrong");
    wr_refuse_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
        else $error("write address taken during answer");
    rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    rd_refuse_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read address taken during answer");
    xfer_drop_a: assert property ((xfer_ack_i & ext_xfer_req_o) != 3'h0 |=> (ext_xfer_req_o & $past(xfer_ack_i)) == 3'h0)
        else $error("transfer request held after ack");
    path_excl_a: assert property ((ext_branch_irq_o & ext_xfer_req_o) == 3'h0)
        else $error("branch and transfer requested together");
endmodule
bind irq_sources irq_sources_asserts chk_u (.*);
`default_nettype wire

// ===== ext_requester.sv
// Model of the peripherals driving the five request inputs.
// Assumes the bench sets the wanted level of each input.
`timescale 1ns/1ps
`default_nettype none
module ext_requester (
    input  wire logic       clk_i,
    input  wire logic [4:0] want_i,
    output logic [3:0]      pin_o,
    output logic            rx_o
);
    // Falling edge, so pins move off the block's sampling edge
    always_ff @(negedge clk_i) begin
        {rx_o, pin_o} <= want_i;
    end
endmodule
`default_nettype wire

// ===== testbench.sv
// Bench for irq_sources: register tasks, delay, external and transfer tests.
// Assumes the design, the checker and ext_requester are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk_i = 1'h0, rst_n_i = 1'h0;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i = 4'hf, ext_irq_pin_i;
    logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0, s_axi_arvalid_i = 1'h0;
    logic s_axi_rready_i = 1'h0, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic s_axi_rvalid_o, can_rx_i, delay_irq_o, irq_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
    logic [2:0] xfer_ack_i = 3'h0, ext_branch_irq_o, ext_xfer_req_o;
    logic [4:0] want = 5'h1f;
    int n_fail = 0, tests_run = 0, i, m;
    irq_sources dut_u (.*);
    ext_requester peer_u (.clk_i(ref_clk_i), .want_i(want), .pin_o(ext_irq_pin_i), .rx_o(can_rx_i));
    always #20 ref_clk_i = ~ref_clk_i;
    // --------
    // Tasks
    // --------
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One spare edge so a following call never re-drives in the same step
    task automatic tmo;
        @(posedge ref_clk_i);
        if (i >= 50) begin
            n_fail++;
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= v;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        s_axi_bready_i <= 1'h1;
        for (i = 0; i < 50 && s_axi_bvalid_o !== 1'h1; i++) begin
            @(posedge ref_clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
        end
        resp = s_axi_bresp_o;
        s_axi_bready_i <= 1'h0;
        tmo();
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'h1;
        s_axi_rready_i <= 1'h1;
        for (i = 0; i < 50 && s_axi_rvalid_o !== 1'h1; i++) begin
            @(posedge ref_clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
        end
        resp = s_axi_rresp_o;
        chk($sformatf("reg %h", a), s_axi_rdata_o, e);
        s_axi_rready_i <= 1'h0;
        tmo();
    endtask
    // --------
    // Tests
    // --------
    initial begin
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'h1;
        repeat (4) @(posedge ref_clk_i);
        rc(8'h14, 32'h1);
        rc(8'h20, 32'h0);
        chk("unmapped resp", resp, 32'h2);
        wr(8'h20, 32'h1);
        chk("unmapped bresp", resp, 32'h2);
        wr(8'h00, 32'h1);
        chk("delay irq", delay_irq_o, 32'h1);
        chk("masked irq", irq_o, 32'h0);
        wr(8'h1c, 32'h1);
        chk("irq", irq_o, 32'h1);
        wr(8'h18, 32'h1);
        chk("cleared irq", irq_o, 32'h0);
        rc(8'h00, 32'h1);
        chk("no transfer", ext_xfer_req_o, 32'h0);
        wr(8'h00, 32'h0);
        chk("delay off", delay_irq_o, 32'h0);
        $display("test delay done");
        // Input m uses mode m mod 4; inactive level first, then the active one
        for (m = 0; m < 5; m++) begin
            want[m] <= (m % 4 == 0 || m % 4 == 3);
            wr(8'h04, (m % 4) << (2 * m));
            wr(8'h0c, 32'h1f);
            wr(8'h08, 1 << m);
            rc(8'h0c, 32'h0);
            want[m] <= !want[m];
            repeat (8) @(posedge ref_clk_i);
            rc(8'h0c, 1 << m);
            chk("branch", ext_branch_irq_o, m < 2 ? 1 : m < 4 ? 2 : 4);
            wr(8'h0c, 32'h1f);
            rc(8'h0c, m % 4 < 2 ? 1 << m : 0);
            wr(8'h08, 32'h0);
            chk("gated", ext_branch_irq_o, 32'h0);
            want[m] <= 1'h1;
        end
        $display("test external done");
        wr(8'h04, 32'h1);
        wr(8'h10, 32'h1);
        wr(8'h14, 32'h2);
        wr(8'h08, 32'h1);
        chk("xfer req", ext_xfer_req_o, 32'h1);
        chk("no branch", ext_branch_irq_o, 32'h0);
        repeat (2) begin
            xfer_ack_i <= 3'h1;
            @(posedge ref_clk_i);
            xfer_ack_i <= 3'h0;
            repeat (3) @(posedge ref_clk_i);
        end
        chk("after xfers", {ext_xfer_req_o, ext_branch_irq_o}, 32'h1);
        $display("test transfer done");
        final_report();
    end
endmodule
`default_nettype wire
